// [rtl/ncr_bank.sv]
// node configuration register bank of the system switch
`timescale 1ns/1ps

// How it works
// - registers reached only by configuration reads and writes by register number
// - identification bits 23:16 return boot control pins caught while reset is held
// - identification holds revision in 15:8, version in 7:0, upper bits reserved
// - description reports serial links, attached processors, device processors
// - configuration bit 31 set blocks writes to all switch control registers
// - configuration bit 8 set blocks writes to the pll control register
// - configuration bit 0 selects one-byte headers when set, two-byte when clear
// - node identifier holds writable 16-bit id in 15:0, upper bits reserved
// - any accepted pll settings write resets the processor tile
// - numbers 0x09 and 0x0a return tap identity and user code, read only
module ncr_bank
  import ncr_pkg::*;
#(
  parameter logic [7:0]  SWITCH_REVISION = 8'h00,
  parameter logic [7:0]  SWITCH_VERSION  = 8'h00,
  parameter logic [7:0]  SERIAL_LINKS    = 8'h04,
  parameter logic [7:0]  SWITCH_PROCS    = 8'h01,
  parameter logic [7:0]  DEVICE_PROCS    = 8'h01,
  // arbitrary values, not any real part's identity
  parameter logic [31:0] TAP_IDENTITY    = 32'h0000_0001,
  parameter logic [31:0] TAP_USER_CODE   = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // configuration access
  input  wire ncr_req_t    req,
  output ncr_rsp_t         rsp,
  // device state inputs
  input  wire logic [7:0]  boot_control_pins,
  input  wire logic [31:0] debug_source_in,
  input  wire logic [31:0] processor_link_in [PROC_LINK_COUNT],
  // controls to the rest of the node
  output logic             one_byte_headers,
  output logic [15:0]      node_id,
  output logic [31:0]      pll_control_register,
  output logic             tile_reset
);

  // boot pins caught on every edge with reset held, then frozen once reset drops
  logic [7:0] boot_capture;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      boot_capture <= boot_control_pins;
    end
  end

  // write gating
  wire logic [31:0] cfg_q;
  wire logic        lock_all  = cfg_q[CFG_LOCK_ALL_BIT];
  wire logic        lock_pll  = cfg_q[CFG_LOCK_PLL_BIT];
  wire logic        wr_ok     = req.wr && !req.rd && !lock_all;
  wire logic        wr_cfg    = wr_ok && req.num == REG_SWITCH_CONFIGURATION;
  wire logic        wr_nid    = wr_ok && req.num == REG_NODE_IDENTIFIER;
  wire logic        wr_pll    = wr_ok && !lock_pll && req.num == REG_PLL_SETTINGS;
  wire logic        wr_div    = wr_ok && req.num == REG_SWITCH_CLOCK_DIVIDER;
  wire logic        wr_ref    = wr_ok && req.num == REG_REFERENCE_CLOCK;
  wire logic        wr_dlo    = wr_ok && req.num == REG_DIRECTIONS_LOW;
  wire logic        wr_dhi    = wr_ok && req.num == REG_DIRECTIONS_HIGH;

  wire logic [31:0] nid_q;
  wire logic [31:0] pll_q;
  wire logic [31:0] div_q;
  wire logic [31:0] ref_q;
  wire logic [31:0] dlo_q;
  wire logic [31:0] dhi_q;

  // only bits 31, 8 and 0 store
  ncr_reg_word #(.MASK(CFG_WRITABLE_MASK), .RESET(RESET_ZERO)) u_cfg (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_cfg),
    .wdata    (req.wdata),
    .q        (cfg_q)
  );
  ncr_reg_word #(.MASK(NODE_ID_MASK), .RESET(RESET_ZERO)) u_nid (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_nid),
    .wdata    (req.wdata),
    .q        (nid_q)
  );
  ncr_reg_word #(.RESET(RESET_PLL_SETTINGS)) u_pll (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_pll),
    .wdata    (req.wdata),
    .q        (pll_q)
  );
  ncr_reg_word u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_div),
    .wdata    (req.wdata),
    .q        (div_q)
  );
  ncr_reg_word u_ref (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_ref),
    .wdata    (req.wdata),
    .q        (ref_q)
  );
  ncr_reg_word u_dlo (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_dlo),
    .wdata    (req.wdata),
    .q        (dlo_q)
  );
  ncr_reg_word u_dhi (
    .core_clk (core_clk),
    .srst     (srst),
    .we       (wr_dhi),
    .wdata    (req.wdata),
    .q        (dhi_q)
  );

  // link register groups
  wire logic [7:0] ls_idx = req.num - REG_LINK_STATUS_BASE;
  wire logic [7:0] pl_idx = req.num - REG_PROC_LINK_BASE;
  wire logic [7:0] lc_idx = req.num - REG_LINK_CONFIG_BASE;
  wire logic [7:0] sl_idx = req.num - REG_STATIC_LINK_BASE;
  wire logic       in_ls  = req.num >= REG_LINK_STATUS_BASE && ls_idx < 8'(LINK_STATUS_COUNT);
  wire logic       in_pl  = req.num >= REG_PROC_LINK_BASE && pl_idx < 8'(PROC_LINK_COUNT);
  wire logic       in_lc  = req.num >= REG_LINK_CONFIG_BASE && lc_idx < 8'(LINK_CONFIG_COUNT);
  wire logic       in_sl  = req.num >= REG_STATIC_LINK_BASE && sl_idx < 8'(STATIC_LINK_COUNT);

  logic [31:0] ls_mem [LINK_STATUS_COUNT];
  logic [31:0] lc_mem [LINK_CONFIG_COUNT];
  logic [31:0] sl_mem [STATIC_LINK_COUNT];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < LINK_STATUS_COUNT; i++) ls_mem[i] <= RESET_ZERO;
      for (int i = 0; i < LINK_CONFIG_COUNT; i++) lc_mem[i] <= RESET_ZERO;
      for (int i = 0; i < STATIC_LINK_COUNT; i++) sl_mem[i] <= RESET_ZERO;
    end else begin
      if (wr_ok && in_ls) ls_mem[ls_idx[3:0]] <= req.wdata;
      if (wr_ok && in_lc) lc_mem[lc_idx[3:0]] <= req.wdata;
      if (wr_ok && in_sl) sl_mem[sl_idx[2:0]] <= req.wdata;
    end
  end

  // read decode; reserved fields are zero
  wire logic [31:0] id_word   = {8'h00, boot_capture, SWITCH_REVISION, SWITCH_VERSION};
  wire logic [31:0] desc_word = {8'h00, SERIAL_LINKS, SWITCH_PROCS, DEVICE_PROCS};
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (req.num)
      REG_NODE_IDENTIFICATION:  rd_word = id_word;
      REG_SWITCH_DESCRIPTION:   rd_word = desc_word;
      REG_SWITCH_CONFIGURATION: rd_word = cfg_q & CFG_WRITABLE_MASK;
      REG_NODE_IDENTIFIER:      rd_word = nid_q & NODE_ID_MASK;
      REG_PLL_SETTINGS:         rd_word = pll_q;
      REG_SWITCH_CLOCK_DIVIDER: rd_word = div_q;
      REG_REFERENCE_CLOCK:      rd_word = ref_q;
      REG_TAP_DEVICE_IDENTITY:  rd_word = TAP_IDENTITY;
      REG_TAP_USER_CODE:        rd_word = TAP_USER_CODE;
      REG_DIRECTIONS_LOW:       rd_word = dlo_q;
      REG_DIRECTIONS_HIGH:      rd_word = dhi_q;
      REG_DEBUG_SOURCE:         rd_word = debug_source_in;
      default: begin
        if (in_ls) begin
          rd_word = ls_mem[ls_idx[3:0]];
        end else if (in_pl) begin
          rd_word = processor_link_in[pl_idx[2:0]];
        end else if (in_lc) begin
          rd_word = lc_mem[lc_idx[3:0]];
        end else if (in_sl) begin
          rd_word = sl_mem[sl_idx[2:0]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // a write to a read-only or unmapped number is answered with err
  wire logic ro_num = req.num == REG_NODE_IDENTIFICATION || req.num == REG_SWITCH_DESCRIPTION
                   || req.num == REG_TAP_DEVICE_IDENTITY || req.num == REG_TAP_USER_CODE
                   || req.num == REG_DEBUG_SOURCE || in_pl;
  wire logic access  = req.rd ^ req.wr;
  wire logic bad     = !rd_hit || (req.wr && ro_num);

  // tile reset pulse counter
  logic [3:0] rst_cnt;
  wire logic [3:0] next_rst_cnt = wr_pll ? TILE_RESET_CYCLES
                                : (rst_cnt != 4'h0 ? rst_cnt - 4'h1 : 4'h0);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp                  <= '0;
      one_byte_headers     <= 1'b0;
      node_id              <= 16'h0000;
      pll_control_register <= RESET_PLL_SETTINGS;
      tile_reset           <= 1'b0;
      rst_cnt              <= 4'h0;
    end else begin
      rsp.ack              <= access;
      rsp.err              <= access && bad;
      rsp.rdata            <= (req.rd && !req.wr) ? rd_word : 32'h0000_0000;
      one_byte_headers     <= wr_cfg ? req.wdata[CFG_HEADER_BIT] : cfg_q[CFG_HEADER_BIT];
      node_id              <= wr_nid ? req.wdata[15:0] : nid_q[15:0];
      pll_control_register <= wr_pll ? req.wdata : pll_q;
      rst_cnt              <= next_rst_cnt;
      tile_reset           <= next_rst_cnt != 4'h0;
    end
  end

  // checks
  lock_all_a: assert property (@(posedge core_clk) disable iff (srst)
    (lock_all && req.wr && !req.rd) |=> $stable(nid_q) && $stable(cfg_q))
    else $error("write taken while all switch registers locked");
  lock_pll_a: assert property (@(posedge core_clk) disable iff (srst)
    (lock_pll && req.wr) |=> $stable(pll_q))
    else $error("pll settings changed while locked");
  header_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 one_byte_headers == cfg_q[CFG_HEADER_BIT])
    else $error("header mode output not following configuration");
  node_id_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_nid) |=> nid_q == {16'h0000, $past(req.wdata[15:0])})
    else $error("node identifier write not stored as 16 bits");
  tile_reset_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_pll |=> tile_reset [*4])
    else $error("tile reset pulse too short after pll write");
  tile_rst_end_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_pll ##1 !wr_pll [*4] |=> !tile_reset)
    else $error("tile reset pulse longer than four cycles");
  tile_rst_cause_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tile_reset) |-> $past(wr_pll))
    else $error("tile reset without pll write");
  ident_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_NODE_IDENTIFICATION)
      |=> rsp.rdata[31:16] == {8'h00, boot_capture} && rsp.rdata[15:0] == {SWITCH_REVISION, SWITCH_VERSION})
    else $error("identification read wrong");
  tap_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_TAP_USER_CODE) |=> rsp.ack && rsp.rdata == TAP_USER_CODE)
    else $error("tap user code read wrong");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_SWITCH_CONFIGURATION) |=> rsp.rdata[30:9] == 22'h0 && rsp.rdata[7:1] == 7'h0)
    else $error("reserved configuration bits read non-zero");

  // answer framing: exactly one ack per single access, silence otherwise
  ack_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd ^ req.wr) |=> rsp.ack)
    else $error("access not acknowledged on the next edge");
  idle_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    !(req.rd ^ req.wr) |=> !rsp.ack && !rsp.err && rsp.rdata == 32'h0000_0000)
    else $error("answer raised without a single access");
  unmapped_err_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == 8'h10) |=> rsp.ack && rsp.err && rsp.rdata == 32'h0000_0000)
    else $error("unmapped number read not refused");

  // read-only numbers refuse writes with err
  ro_write_err_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && !req.rd && req.num == REG_TAP_USER_CODE) |=> rsp.ack && rsp.err)
    else $error("write to tap user code not refused");
  ident_write_err_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && !req.rd && req.num == REG_NODE_IDENTIFICATION) |=> rsp.ack && rsp.err)
    else $error("write to identification not refused");

  // a locked write is acked quietly and changes nothing
  lock_ack_a: assert property (@(posedge core_clk) disable iff (srst)
    (lock_all && req.wr && !req.rd && req.num == REG_NODE_IDENTIFIER) |=> rsp.ack && !rsp.err)
    else $error("locked write not acknowledged cleanly");
  lock_clock_a: assert property (@(posedge core_clk) disable iff (srst)
    (lock_all && req.wr && !req.rd) |=> $stable(div_q) && $stable(ref_q) && $stable(dlo_q) && $stable(dhi_q))
    else $error("clock or direction register written while locked");
  tile_rst_lock_a: assert property (@(posedge core_clk) disable iff (srst)
    (lock_pll && req.wr && !req.rd && req.num == REG_PLL_SETTINGS && !tile_reset) |=> !tile_reset)
    else $error("tile reset from a locked pll write");

  // outputs follow accepted writes
  pll_out_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_pll |=> pll_control_register == $past(req.wdata) && pll_q == $past(req.wdata))
    else $error("pll settings not updated by accepted write");
  node_id_out_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_nid |=> node_id == $past(req.wdata[15:0]))
    else $error("node identifier output not updated");
  cfg_mask_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_cfg |=> (cfg_q & ~CFG_WRITABLE_MASK) == 32'h0000_0000)
    else $error("reserved configuration bits stored");

  // read-only content
  boot_frozen_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 $stable(boot_capture))
    else $error("boot pin capture moved outside reset");
  desc_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_SWITCH_DESCRIPTION) |=> rsp.rdata == {8'h00, SERIAL_LINKS, SWITCH_PROCS, DEVICE_PROCS})
    else $error("switch description read wrong");
  tap_id_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_TAP_DEVICE_IDENTITY) |=> rsp.ack && rsp.rdata == TAP_IDENTITY)
    else $error("tap identity read wrong");
  nid_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && !req.wr && req.num == REG_NODE_IDENTIFIER) |=> rsp.rdata[31:16] == 16'h0000)
    else $error("reserved node identifier bits read non-zero");

endmodule

// [rtl/ncr_pkg.sv]
// constants and carrier types for the node configuration register bank
package ncr_pkg;

  // register numbers
  localparam logic [7:0] REG_NODE_IDENTIFICATION  = 8'h00;
  localparam logic [7:0] REG_SWITCH_DESCRIPTION   = 8'h01;
  localparam logic [7:0] REG_SWITCH_CONFIGURATION = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER      = 8'h05;
  localparam logic [7:0] REG_PLL_SETTINGS         = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK      = 8'h08;
  localparam logic [7:0] REG_TAP_DEVICE_IDENTITY  = 8'h09;
  localparam logic [7:0] REG_TAP_USER_CODE        = 8'h0a;
  localparam logic [7:0] REG_DIRECTIONS_LOW       = 8'h0c;
  localparam logic [7:0] REG_DIRECTIONS_HIGH      = 8'h0d;
  localparam logic [7:0] REG_DEBUG_SOURCE         = 8'h1f;
  localparam logic [7:0] REG_LINK_STATUS_BASE     = 8'h20;
  localparam logic [7:0] REG_PROC_LINK_BASE       = 8'h40;
  localparam logic [7:0] REG_LINK_CONFIG_BASE     = 8'h80;
  localparam logic [7:0] REG_STATIC_LINK_BASE     = 8'ha0;
  localparam int         LINK_STATUS_COUNT        = 9;
  localparam int         PROC_LINK_COUNT          = 8;
  localparam int         LINK_CONFIG_COUNT        = 9;
  localparam int         STATIC_LINK_COUNT        = 8;

  // switch configuration field positions
  localparam int CFG_LOCK_ALL_BIT = 31;
  localparam int CFG_LOCK_PLL_BIT = 8;
  localparam int CFG_HEADER_BIT   = 0;
  localparam logic [31:0] CFG_WRITABLE_MASK = 32'h8000_0101;
  localparam logic [31:0] NODE_ID_MASK      = 32'h0000_ffff;

  // reset values
  localparam logic [31:0] RESET_ZERO          = 32'h0000_0000;
  localparam logic [31:0] RESET_PLL_SETTINGS  = 32'h0000_0000;

  // tile reset pulse length
  localparam int         TILE_RESET_NS     = 20;
  localparam int         CLK_PERIOD_NS     = 5;
  localparam logic [3:0] TILE_RESET_CYCLES = 4'((TILE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {ACC_RW, ACC_RO, ACC_NONE} ncr_access_t;

  // configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  num;
    logic [31:0] wdata;
  } ncr_req_t;

  // configuration access answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } ncr_rsp_t;

endpackage

// [rtl/ncr_reg_word.sv]
// one writable register word with a write-enable mask
`timescale 1ns/1ps
module ncr_reg_word
  import ncr_pkg::*;
#(
  parameter logic [31:0] MASK  = 32'hffff_ffff,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // write port
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  // stored value
  output logic      [31:0] q
);

  wire logic [31:0] next_q = (q & ~MASK) | (wdata & MASK);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= RESET;
    end else if (we) begin
      q <= next_q;
    end
  end

endmodule

// [verification/ncr_bank_tb.sv]
// self-checking bench for the node configuration register bank
`timescale 1ns/1ps
module ncr_bank_tb
  import ncr_pkg::*;
();
  // arbitrary identity values, not those of any real part
  localparam logic [31:0] TAP_ID = 32'h1234_5679;
  localparam logic [31:0] TAP_UC = 32'h0bad_cafe;

  logic        core_clk = 1'b0;
  logic        srst;
  ncr_req_t    req;
  ncr_rsp_t    rsp;
  logic [7:0]  boot_pins;
  logic [31:0] dbg_src;
  logic [31:0] processor_link [PROC_LINK_COUNT];
  logic        hdr1;
  logic [15:0] nid;
  logic [31:0] pll;
  logic        tile_rst;
  int          n_fail = 0;
  int          n_tests = 0;

  always #2.5 core_clk = ~core_clk;

  ncr_bank #(
    .SWITCH_REVISION(8'h12), .SWITCH_VERSION(8'h34), .SERIAL_LINKS(8'h05),
    .SWITCH_PROCS(8'h02), .DEVICE_PROCS(8'h03), .TAP_IDENTITY(TAP_ID), .TAP_USER_CODE(TAP_UC)
  ) u_ncr_bank (
    .core_clk(core_clk), .srst(srst), .req(req), .rsp(rsp),
    .boot_control_pins(boot_pins), .debug_source_in(dbg_src), .processor_link_in(processor_link),
    .one_byte_headers(hdr1), .node_id(nid), .pll_control_register(pll), .tile_reset(tile_rst)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request is level sampled, so it is dropped right after the taking edge
  task automatic acc(input logic r, input logic w, input logic [7:0] num, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int k;
    // one idle edge keeps the last release and this request apart
    @(posedge core_clk);
    #1 req = '{rd: r, wr: w, num: num, wdata: wd};
    @(posedge core_clk);
    #1 req = '0;
    k = 0;
    while (rsp.ack !== 1'b1 && k < 4) begin
      @(posedge core_clk);
      #1 k++;
    end
    if (k == 4) begin
      n_fail++;
      $display("BAD %0t no answer", $time);
      stop_test();
    end
    d = rsp.rdata;
    e = rsp.err;
  endtask

  task automatic wr(input logic [7:0] num, input logic [31:0] wd, input logic ee);
    logic [31:0] d;
    logic        e;
    acc(1'b0, 1'b1, num, wd, d, e);
    check(32'(e), 32'(ee));
  endtask

  task automatic rd_chk(input logic [7:0] num, input logic [31:0] exp, input logic ee);
    logic [31:0] d;
    logic        e;
    acc(1'b1, 1'b0, num, 32'h0, d, e);
    check(d, exp);
    check(32'(e), 32'(ee));
  endtask

  // length of the tile reset pulse, allowing a short start delay
  task automatic pulse_len(output logic [31:0] n);
    int k;
    n = 32'h0;
    k = 0;
    while (tile_rst !== 1'b1 && k < 2) begin
      @(posedge core_clk);
      #1 k++;
    end
    while (tile_rst === 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 srst = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_ident();
    check(32'({hdr1, nid, tile_rst}), 32'h0);
    check(pll, 32'h0);
    rd_chk(REG_NODE_IDENTIFICATION, 32'h00a5_1234, 1'b0);
    rd_chk(REG_SWITCH_DESCRIPTION, 32'h0005_0203, 1'b0);
    rd_chk(REG_TAP_DEVICE_IDENTITY, TAP_ID, 1'b0);
    rd_chk(REG_TAP_USER_CODE, TAP_UC, 1'b0);
    wr(REG_TAP_USER_CODE, 32'hffff_ffff, 1'b1);
    wr(REG_NODE_IDENTIFICATION, 32'hffff_ffff, 1'b1);
    wr(REG_SWITCH_DESCRIPTION, 32'hffff_ffff, 1'b1);
    rd_chk(REG_NODE_IDENTIFICATION, 32'h00a5_1234, 1'b0);
  endtask

  task automatic t_node_id();
    wr(REG_NODE_IDENTIFIER, 32'hffff_abcd, 1'b0);
    rd_chk(REG_NODE_IDENTIFIER, 32'h0000_abcd, 1'b0);
    check(32'(nid), 32'h0000_abcd);
  endtask

  task automatic t_header();
    wr(REG_SWITCH_CONFIGURATION, 32'h7fff_fe01, 1'b0);
    rd_chk(REG_SWITCH_CONFIGURATION, 32'h0000_0001, 1'b0);
    check(32'(hdr1), 32'h1);
    wr(REG_SWITCH_CONFIGURATION, 32'h0, 1'b0);
    rd_chk(REG_SWITCH_CONFIGURATION, 32'h0, 1'b0);
    check(32'(hdr1), 32'h0);
  endtask

  task automatic t_pll();
    logic [31:0] n;
    wr(REG_PLL_SETTINGS, 32'hdead_0042, 1'b0);
    pulse_len(n);
    check(n, 32'h4);
    check(pll, 32'hdead_0042);
    wr(REG_SWITCH_CONFIGURATION, 32'h0000_0100, 1'b0);
    wr(REG_PLL_SETTINGS, 32'h1111_1111, 1'b0);
    pulse_len(n);
    check(n, 32'h0);
    rd_chk(REG_PLL_SETTINGS, 32'hdead_0042, 1'b0);
    check(pll, 32'hdead_0042);
    wr(REG_SWITCH_CONFIGURATION, 32'h0, 1'b0);
    wr(REG_PLL_SETTINGS, 32'h0000_0077, 1'b0);
    pulse_len(n);
    check(n, 32'h4);
    rd_chk(REG_PLL_SETTINGS, 32'h0000_0077, 1'b0);
  endtask

  task automatic t_live();
    rd_chk(REG_DEBUG_SOURCE, 32'h5a5a_0f0f, 1'b0);
    dbg_src = 32'h0f0f_5a5a;
    rd_chk(REG_DEBUG_SOURCE, 32'h0f0f_5a5a, 1'b0);
    rd_chk(REG_PROC_LINK_BASE + 8'h03, 32'h1000_0003, 1'b0);
    wr(REG_PROC_LINK_BASE, 32'h0, 1'b1);
    rd_chk(8'h10, 32'h0, 1'b1);
    rd_chk(8'h02, 32'h0, 1'b1);
    rd_chk(REG_LINK_STATUS_BASE + 8'h09, 32'h0, 1'b1);
    wr(REG_STATIC_LINK_BASE + 8'h07, 32'hcafe_f00d, 1'b0);
    rd_chk(REG_STATIC_LINK_BASE + 8'h07, 32'hcafe_f00d, 1'b0);
  endtask

  task automatic t_lock();
    wr(REG_SWITCH_CLOCK_DIVIDER, 32'h0000_0003, 1'b0);
    wr(REG_SWITCH_CONFIGURATION, 32'h8000_0000, 1'b0);
    wr(REG_NODE_IDENTIFIER, 32'h0000_1234, 1'b0);
    wr(REG_SWITCH_CLOCK_DIVIDER, 32'h0000_0009, 1'b0);
    wr(REG_SWITCH_CONFIGURATION, 32'h0, 1'b0);
    rd_chk(REG_NODE_IDENTIFIER, 32'h0000_abcd, 1'b0);
    rd_chk(REG_SWITCH_CLOCK_DIVIDER, 32'h0000_0003, 1'b0);
    rd_chk(REG_SWITCH_CONFIGURATION, 32'h8000_0000, 1'b0);
    // only a reset lifts the global lock
    do_reset();
    check(32'({hdr1, nid, tile_rst}), 32'h0);
    check(pll, 32'h0);
    rd_chk(REG_SWITCH_CONFIGURATION, 32'h0, 1'b0);
    rd_chk(REG_NODE_IDENTIFIER, 32'h0, 1'b0);
    rd_chk(REG_NODE_IDENTIFICATION, 32'h003c_1234, 1'b0);
  endtask

  initial begin
    srst = 1'b1;
    req = '0;
    boot_pins = 8'ha5;
    dbg_src = 32'h5a5a_0f0f;
    foreach (processor_link[i]) processor_link[i] = 32'h1000_0000 + 32'(i);
    do_reset();
    boot_pins = 8'h3c;
    t_ident();
    t_node_id();
    t_header();
    t_pll();
    t_live();
    t_lock();
    stop_test();
  end
endmodule
